// *** logic/pcs_consts.svh ***
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define PCS_ADDR_W 12
`define PCS_CTRL_OFFSET 12'h1c4

// ****************************************
// Field positions in power_control
// ****************************************
`define PCS_BIT_BUTTON 31
`define PCS_BIT_BATTERY 29
`define PCS_BIT_DIV16 26
`define PCS_BIT_MODFREE 25
`define PCS_CMP_HI 15
`define PCS_CMP_LO 12
`define PCS_BIT_TIMER_EN 11
`define PCS_BIT_FO_EN 10
`define PCS_BIT_FO_ARMED 9
`define PCS_BIT_FO_EVENT 8
`define PCS_BIT_SHORT 7
`define PCS_BIT_BYPASS 5
`define PCS_BIT_HALT 4
`define PCS_BIT_DEBOUNCE 3
`define PCS_BIT_POWER_ON 2
`define PCS_BIT_SUPPLY 1
`define PCS_BIT_RAIL 0

// ****************************************
// Reset values
// ****************************************
`define PCS_RST_BIT 1'b0
`define PCS_RST_POWER_ON 1'b1
`define PCS_RST_COMPARE 4'h0

// ****************************************
// Timing, in ms, and tick counts derived
// ****************************************
`define PCS_TICK_SHORT_MS 2
`define PCS_TICK_LONG_MS 8
`define PCS_SHORT_MIN_MS 4
`define PCS_LONG_MIN_MS 16
`define PCS_DEBOUNCE_MIN_MS 16
`define PCS_SHORT_TICKS (`PCS_SHORT_MIN_MS / `PCS_TICK_SHORT_MS + 1)
`define PCS_LONG_TICKS (`PCS_LONG_MIN_MS / `PCS_TICK_LONG_MS + 1)
`define PCS_DEBOUNCE_TICKS (`PCS_DEBOUNCE_MIN_MS / `PCS_TICK_LONG_MS + 1)
`define PCS_DIV16_RATIO 16

`endif

// *** logic/pcs_pkg.sv ***
`include "pcs_consts.svh"

package pcs_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PCS_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pcs_apb_req_s;

  typedef struct packed {
    logic sysclk_div16_sel;
    logic module_clock_free_sel;
    logic [3:0] stop_timer_compare;
    logic stop_timer_en;
    logic forced_off_enable;
    logic short_settle_sel;
    logic settle_bypass;
    logic button_debounce_en;
  } pcs_ctrl_s;

  typedef enum logic [1:0] {
    SETTLE_OFF,
    SETTLE_WAIT,
    SETTLE_OK
  } pcs_settle_e;

endpackage : pcs_pkg

// *** logic/pcs_settle.sv ***
`timescale 1ns/100ps
`include "pcs_consts.svh"

module pcs_settle #(
  parameter int CNT_W = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Rail and ticks
  input wire logic main_rail_in,
  input wire logic tick_2ms_in,
  input wire logic tick_8ms_in,
  // Control
  input wire logic short_settle_sel_in,
  input wire logic settle_bypass_in,
  // Status
  output logic clock_ok_out
);

  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(`PCS_SHORT_TICKS - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(`PCS_LONG_TICKS - 1);

  pcs_pkg::pcs_settle_e state;
  logic [CNT_W-1:0] ticks;
  logic tick;
  logic [CNT_W-1:0] last;

  // First tick lands anywhere in one period, hence one tick extra
  assign tick = short_settle_sel_in ? tick_2ms_in : tick_8ms_in;
  assign last = short_settle_sel_in ? SHORT_LAST : LONG_LAST;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= pcs_pkg::SETTLE_OFF;
      ticks <= '0;
    end else begin
      case (state)
        pcs_pkg::SETTLE_OFF: begin
          ticks <= '0;
          if (main_rail_in) begin
            state <= settle_bypass_in ? pcs_pkg::SETTLE_OK : pcs_pkg::SETTLE_WAIT;
          end
        end
        pcs_pkg::SETTLE_WAIT: begin
          if (!main_rail_in) begin
            state <= pcs_pkg::SETTLE_OFF;
          end else if (settle_bypass_in) begin
            state <= pcs_pkg::SETTLE_OK;
          end else if (tick) begin
            if (ticks == last) begin
              state <= pcs_pkg::SETTLE_OK;
            end else begin
              ticks <= ticks + 1'b1;
            end
          end
        end
        pcs_pkg::SETTLE_OK: begin
          if (!main_rail_in) begin
            state <= pcs_pkg::SETTLE_OFF;
          end
        end
        default: state <= pcs_pkg::SETTLE_OFF;
      endcase
    end
  end

  assign clock_ok_out = (state == pcs_pkg::SETTLE_OK);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_settle_bypass: assert property (
    $rose(main_rail_in) && settle_bypass_in && !clock_ok_out |=> clock_ok_out)
    else $error("Bypass did not release the clock at once");
  chk_settle_release: assert property (
    $rose(clock_ok_out) |-> $past(settle_bypass_in) || $past(tick) && $past(ticks) == $past(last))
    else $error("Clock released before the settle delay");

endmodule : pcs_settle

// *** logic/pcs_debounce.sv ***
`timescale 1ns/100ps
`include "pcs_consts.svh"

module pcs_debounce #(
  parameter int CNT_W = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Tick and button
  input wire logic tick_8ms_in,
  input wire logic power_button_in,
  input wire logic en_in,
  // Filtered level
  output logic stable_out
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(`PCS_DEBOUNCE_TICKS - 1);

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stable_out <= 1'b0;
      cnt <= '0;
    end else if (!en_in) begin
      stable_out <= power_button_in;
      cnt <= '0;
    end else if (power_button_in == stable_out) begin
      cnt <= '0;
    end else if (tick_8ms_in) begin
      if (cnt == LAST) begin
        stable_out <= power_button_in;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_debounce_wait: assert property (
    $past(en_in) && $changed(stable_out) |-> $past(tick_8ms_in) && $past(cnt) == LAST)
    else $error("Button level passed before the debounce time");

endmodule : pcs_debounce

// *** logic/pcs_power_ctrl.sv ***
`timescale 1ns/100ps
`include "pcs_consts.svh"

module pcs_power_ctrl #(
  parameter int DIV_RATIO = `PCS_DIV16_RATIO,
  parameter int TIMER_W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire pcs_pkg::pcs_apb_req_s apb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Supply, battery and button
  input wire logic battery_good_in,
  input wire logic power_button_in,
  input wire logic main_rail_in,
  input wire logic irq_pending_in,
  output logic supply_request_out,
  output logic rail_on_warning_out,
  // Time base ticks
  input wire logic tick_2ms_in,
  input wire logic tick_8ms_in,
  // Clock gating
  output logic sysclk_en_out,
  output logic module_clk_en_out,
  output logic core_clk_en_out,
  // Interrupt events
  output logic stop_timer_irq_out,
  output logic button_rise_irq_out,
  output logic button_fall_irq_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  function automatic logic addr_hit(input logic [`PCS_ADDR_W-1:0] addr);
    addr_hit = (addr == `PCS_CTRL_OFFSET);
  endfunction : addr_hit

  logic setup;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rd_word;

  assign setup = apb_in.psel && !apb_in.penable;
  assign wr = apb_in.psel && apb_in.penable && apb_in.pwrite && addr_hit(apb_in.paddr);
  assign wdata = apb_in.pwdata;
  // Zero wait states; unmapped accesses answer with an error
  assign pready_out = 1'b1;
  assign pslverr_out = apb_in.psel && apb_in.penable && !addr_hit(apb_in.paddr);

  // ****************************************
  // Control state
  // ****************************************
  pcs_pkg::pcs_ctrl_s ctrl;
  logic forced_off_armed;
  logic forced_off_event;
  logic core_clock_halt;
  logic power_on_flag;
  logic supply_request;
  logic rail_on_warning;
  logic battery_q;
  logic button_eff;
  logic button_q;
  logic button_press;
  logic wake;
  logic battery_fall;
  logic forced_off;

  assign button_press = button_eff && !button_q;
  assign wake = battery_good_in && (button_press || irq_pending_in);
  assign battery_fall = battery_q && !battery_good_in;
  assign forced_off = ctrl.forced_off_enable && forced_off_armed && battery_fall;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.sysclk_div16_sel <= `PCS_RST_BIT;
      ctrl.module_clock_free_sel <= `PCS_RST_BIT;
      ctrl.stop_timer_compare <= `PCS_RST_COMPARE;
      ctrl.stop_timer_en <= `PCS_RST_BIT;
      ctrl.forced_off_enable <= `PCS_RST_BIT;
      ctrl.short_settle_sel <= `PCS_RST_BIT;
      ctrl.settle_bypass <= `PCS_RST_BIT;
      ctrl.button_debounce_en <= `PCS_RST_BIT;
    end else if (wr) begin
      ctrl.sysclk_div16_sel <= wdata[`PCS_BIT_DIV16];
      ctrl.module_clock_free_sel <= wdata[`PCS_BIT_MODFREE];
      ctrl.stop_timer_compare <= wdata[`PCS_CMP_HI:`PCS_CMP_LO];
      ctrl.stop_timer_en <= wdata[`PCS_BIT_TIMER_EN];
      ctrl.forced_off_enable <= wdata[`PCS_BIT_FO_EN];
      ctrl.short_settle_sel <= wdata[`PCS_BIT_SHORT];
      ctrl.settle_bypass <= wdata[`PCS_BIT_BYPASS];
      ctrl.button_debounce_en <= wdata[`PCS_BIT_DEBOUNCE];
    end
  end

  // Supply outputs: forced shutdown first, then wake, then software
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      supply_request <= `PCS_RST_BIT;
      rail_on_warning <= `PCS_RST_BIT;
    end else if (forced_off) begin
      supply_request <= 1'b0;
      rail_on_warning <= 1'b0;
    end else if (wake) begin
      supply_request <= 1'b1;
      rail_on_warning <= 1'b1;
    end else if (wr) begin
      // Clearing is refused while an enabled interrupt is pending
      supply_request <= wdata[`PCS_BIT_SUPPLY] || (irq_pending_in && supply_request);
      rail_on_warning <= wdata[`PCS_BIT_RAIL] || (irq_pending_in && rail_on_warning);
    end
  end

  // Armed by a wake from off or by a software write of 1; set wins over a software clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      forced_off_armed <= `PCS_RST_BIT;
    end else if (wake && !supply_request) begin
      forced_off_armed <= 1'b1;
    end else if (wr) begin
      forced_off_armed <= wdata[`PCS_BIT_FO_ARMED];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      forced_off_event <= `PCS_RST_BIT;
    end else if (forced_off) begin
      forced_off_event <= 1'b1;
    end else if (wr) begin
      forced_off_event <= wdata[`PCS_BIT_FO_EVENT];
    end
  end

  // Hardware clear wins so a pending interrupt always restarts the core
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_clock_halt <= `PCS_RST_BIT;
    end else if (irq_pending_in) begin
      core_clock_halt <= 1'b0;
    end else if (wr) begin
      core_clock_halt <= wdata[`PCS_BIT_HALT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      power_on_flag <= `PCS_RST_POWER_ON;
    end else if (wr) begin
      power_on_flag <= wdata[`PCS_BIT_POWER_ON];
    end
  end

  assign supply_request_out = supply_request;
  assign rail_on_warning_out = rail_on_warning;

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rd_word = '0;
    rd_word[`PCS_BIT_BUTTON] = power_button_in;
    rd_word[`PCS_BIT_BATTERY] = battery_good_in;
    rd_word[`PCS_BIT_DIV16] = ctrl.sysclk_div16_sel;
    rd_word[`PCS_BIT_MODFREE] = ctrl.module_clock_free_sel;
    rd_word[`PCS_CMP_HI:`PCS_CMP_LO] = ctrl.stop_timer_compare;
    rd_word[`PCS_BIT_TIMER_EN] = ctrl.stop_timer_en;
    rd_word[`PCS_BIT_FO_EN] = ctrl.forced_off_enable;
    rd_word[`PCS_BIT_FO_ARMED] = forced_off_armed;
    rd_word[`PCS_BIT_FO_EVENT] = forced_off_event;
    rd_word[`PCS_BIT_SHORT] = ctrl.short_settle_sel;
    rd_word[`PCS_BIT_BYPASS] = ctrl.settle_bypass;
    rd_word[`PCS_BIT_HALT] = core_clock_halt;
    rd_word[`PCS_BIT_DEBOUNCE] = ctrl.button_debounce_en;
    rd_word[`PCS_BIT_POWER_ON] = power_on_flag;
    rd_word[`PCS_BIT_SUPPLY] = supply_request;
    rd_word[`PCS_BIT_RAIL] = rail_on_warning;
  end

  // Captured in setup so the access phase sees a registered value
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= '0;
    end else if (setup) begin
      prdata_out <= addr_hit(apb_in.paddr) ? rd_word : '0;
    end
  end

  // ****************************************
  // Stop timer
  // ****************************************
  logic [TIMER_W-1:0] timer_cnt;
  logic timer_match;
  logic timer_match_q;

  assign timer_match = ctrl.stop_timer_en && (timer_cnt == ctrl.stop_timer_compare);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_cnt <= '0;
    end else if (!ctrl.stop_timer_en) begin
      timer_cnt <= '0;
    end else if (tick_8ms_in) begin
      timer_cnt <= timer_cnt + 1'b1;
    end
  end

  // One event per match, not one per cycle the match holds
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_match_q <= 1'b0;
      stop_timer_irq_out <= 1'b0;
    end else begin
      timer_match_q <= timer_match;
      stop_timer_irq_out <= timer_match && !timer_match_q;
    end
  end

  // ****************************************
  // Power button
  // ****************************************
  logic button_stable;

  pcs_debounce #(
    .CNT_W(2)
  ) u_debounce (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .tick_8ms_in(tick_8ms_in),
    .power_button_in(power_button_in),
    .en_in(ctrl.button_debounce_en),
    .stable_out(button_stable)
  );

  assign button_eff = ctrl.button_debounce_en ? button_stable : power_button_in;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      button_q <= 1'b0;
      battery_q <= 1'b0;
      button_rise_irq_out <= 1'b0;
      button_fall_irq_out <= 1'b0;
    end else begin
      button_q <= button_eff;
      battery_q <= battery_good_in;
      button_rise_irq_out <= button_eff && !button_q;
      button_fall_irq_out <= !button_eff && button_q;
    end
  end

  // ****************************************
  // Clock settle and gating
  // ****************************************
  logic clock_ok;
  logic [3:0] div_cnt;
  logic div_tick;
  logic next_sysclk_en;

  pcs_settle #(
    .CNT_W(2)
  ) u_settle (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .main_rail_in(main_rail_in),
    .tick_2ms_in(tick_2ms_in),
    .tick_8ms_in(tick_8ms_in),
    .short_settle_sel_in(ctrl.short_settle_sel),
    .settle_bypass_in(ctrl.settle_bypass),
    .clock_ok_out(clock_ok)
  );

  assign div_tick = (div_cnt == 4'(DIV_RATIO - 1));
  // Reduce-frequency field stays in the clock module; only the extra divide is here
  assign next_sysclk_en = clock_ok && (!ctrl.sysclk_div16_sel || div_tick);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sysclk_en_out <= 1'b0;
      module_clk_en_out <= 1'b0;
      core_clk_en_out <= 1'b0;
    end else begin
      sysclk_en_out <= next_sysclk_en;
      module_clk_en_out <= ctrl.module_clock_free_sel ? clock_ok : next_sysclk_en;
      core_clk_en_out <= next_sysclk_en && !core_clock_halt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  chk_div16_spacing: assert property (
    $past(ctrl.sysclk_div16_sel, 2) && $past(ctrl.sysclk_div16_sel) && sysclk_en_out
    |-> !$past(sysclk_en_out))
    else $error("Divided system clock enable too frequent");
  chk_free_module_clk: assert property (
    $past(clock_ok && ctrl.module_clock_free_sel) |-> module_clk_en_out)
    else $error("Module clock not on free-running source");
  chk_timer_irq: assert property (
    stop_timer_irq_out |-> $past(ctrl.stop_timer_en && timer_cnt == ctrl.stop_timer_compare))
    else $error("Stop timer event without compare match");
  chk_timer_hold: assert property (
    !ctrl.stop_timer_en |=> timer_cnt == '0)
    else $error("Stop timer not held at zero");
  chk_arm_on_wake: assert property (
    wake && !supply_request |=> forced_off_armed && supply_request)
    else $error("Wake from off did not arm forced-off");
  chk_forced_off: assert property (
    forced_off |=> !supply_request && !rail_on_warning && forced_off_event)
    else $error("Forced shutdown did not drop supply");
  chk_no_force_off: assert property (
    !ctrl.forced_off_enable && supply_request && !wr |=> supply_request)
    else $error("Supply dropped with forced shutdown disabled");
  chk_wake_supply: assert property (
    wake |=> supply_request && rail_on_warning)
    else $error("Wake did not raise supply bits");
  chk_pending_hold: assert property (
    irq_pending_in && supply_request && !forced_off |=> supply_request)
    else $error("Supply cleared while interrupt pending");
  chk_halt_core: assert property (
    core_clock_halt |=> !core_clk_en_out)
    else $error("Core clock ran while halted");
  chk_power_on: assert property (
    $rose(rst_n) |-> power_on_flag)
    else $error("Power-on flag clear after reset");

endmodule : pcs_power_ctrl

// *** dv/pcs_supply_model.sv ***
`timescale 1ns/100ps

// ****
// Supply and time base stand-in
// ****
module pcs_supply_model #(
  parameter int T2 = 20,
  parameter int RAIL_DLY = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request
  input wire logic supply_request_in,
  // Rail and ticks
  output logic main_rail_out,
  output logic tick_2ms_out,
  output logic tick_8ms_out
);
  logic [7:0] div;
  logic [3:0] dly;

  // Shortened tick periods keep the 1:4 ratio
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div <= 8'h00;
      tick_2ms_out <= 1'b0;
      tick_8ms_out <= 1'b0;
    end else begin
      div <= (int'(div) == 4 * T2 - 1) ? 8'h00 : div + 8'h01;
      tick_2ms_out <= (int'(div) % T2) == T2 - 1;
      tick_8ms_out <= int'(div) == 4 * T2 - 1;
    end
  end

  // Rail lags the request, drops at once when it is withdrawn
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dly <= 4'h0;
      main_rail_out <= 1'b0;
    end else if (!supply_request_in) begin
      dly <= 4'h0;
      main_rail_out <= 1'b0;
    end else if (int'(dly) == RAIL_DLY) begin
      main_rail_out <= 1'b1;
    end else begin
      dly <= dly + 4'h1;
    end
  end
endmodule : pcs_supply_model

// *** dv/pcs_power_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "pcs_consts.svh"

module pcs_power_ctrl_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  pcs_pkg::pcs_apb_req_s req = '0;
  logic bat = 1'b1;
  logic btn = 1'b0;
  logic irq = 1'b0;
  logic pready, e, rail, t2, t8, sup, warn, sys_en, mod_en, core_en, st_irq, rise;
  logic fall, qe;
  logic [31:0] prdata, q, cfg;
  int n_errors = 0;
  int cmp_count = 0;
  int n, a, b;

  always #5 clk_in = ~clk_in;

  pcs_power_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(req), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(e), .battery_good_in(bat), .power_button_in(btn),
    .main_rail_in(rail), .irq_pending_in(irq), .supply_request_out(sup),
    .rail_on_warning_out(warn), .tick_2ms_in(t2), .tick_8ms_in(t8), .sysclk_en_out(sys_en),
    .module_clk_en_out(mod_en), .core_clk_en_out(core_en), .stop_timer_irq_out(st_irq),
    .button_rise_irq_out(rise), .button_fall_irq_out(fall));

  pcs_supply_model model (.clk_in(clk_in), .rst_n_in(rst_n_in), .supply_request_in(sup),
    .main_rail_out(rail), .tick_2ms_out(t2), .tick_8ms_out(t8));

  // ****
  // Helpers
  // ****
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic apb(input bit w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      end_of_test();
    end
    q = prdata;
    qe = e;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d);
    apb(1'b1, `PCS_CTRL_OFFSET, d);
  endtask : wr

  task automatic rd();
    apb(1'b0, `PCS_CTRL_OFFSET, 32'h0000_0000);
  endtask : rd

  // Sampled on the falling edge, away from register updates
  task automatic wt(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_in);
      k++;
    end
    if (s !== v) begin
      n_errors++;
      end_of_test();
    end
  endtask : wt

  task automatic press();
    @(posedge clk_in);
    btn <= 1'b1;
    wt(sup, 1'b1, 6, n);
    @(posedge clk_in);
    btn <= 1'b0;
  endtask : press

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rd();
    chk("reset value", q, 32'h2000_0004);
    chk("mapped error", qe, 1'b0);
    apb(1'b0, 12'h1c0, 32'h0000_0000);
    chk("unmapped data", q, 32'h0000_0000);
    chk("unmapped error", qe, 1'b1);
  endtask : t_regs

  task automatic t_wake();
    @(posedge clk_in);
    bat <= 1'b0;
    btn <= 1'b1;
    repeat (5) @(negedge clk_in);
    chk("no wake on low battery", sup, 1'b0);
    @(posedge clk_in);
    btn <= 1'b0;
    bat <= 1'b1;
    repeat (2) @(posedge clk_in);
    btn <= 1'b1;
    wt(rise, 1'b1, 4, n);
    chk("wake supply", {sup, warn}, 2'b11);
    @(negedge clk_in);
    chk("rise pulse", rise, 1'b0);
    rd();
    chk("armed after wake", q, 32'ha000_0207);
    @(posedge clk_in);
    btn <= 1'b0;
    wt(fall, 1'b1, 4, n);
    chk("fall pulse", fall, 1'b1);
    wt(rail, 1'b1, 20, n);
    wt(sys_en, 1'b1, 300, n);
    chk("long settle", n >= 158 && n <= 245, 1'b1);
  endtask : t_wake

  task automatic t_settle();
    cfg = 32'h0000_0080;
    wr(cfg);
    wt(rail, 1'b0, 20, n);
    // Settle state and enable flop trail the rail by two edges
    repeat (2) @(negedge clk_in);
    chk("sys blocked", sys_en, 1'b0);
    press();
    wt(rail, 1'b1, 20, n);
    wt(sys_en, 1'b1, 300, n);
    chk("short settle", n >= 38 && n <= 65, 1'b1);
    cfg = 32'h0000_00a0;
    wr(cfg);
    wt(rail, 1'b0, 20, n);
    press();
    wt(rail, 1'b1, 20, n);
    wt(sys_en, 1'b1, 8, n);
    chk("bypass settle", n <= 3, 1'b1);
  endtask : t_settle

  task automatic t_forced();
    cfg = 32'h0000_00a3;
    @(posedge clk_in);
    bat <= 1'b0;
    repeat (5) @(negedge clk_in);
    chk("no forced off", sup, 1'b1);
    @(posedge clk_in);
    bat <= 1'b1;
    wr(cfg | 32'h0000_0600);
    @(posedge clk_in);
    bat <= 1'b0;
    wt(sup, 1'b0, 5, n);
    chk("forced warn", warn, 1'b0);
    @(posedge clk_in);
    bat <= 1'b1;
    rd();
    chk("event set", q[8], 1'b1);
    press();
    wr(cfg);
    rd();
    chk("event cleared", q[9:8], 2'b00);
  endtask : t_forced

  task automatic t_halt();
    wt(sys_en, 1'b1, 40, n);
    @(posedge clk_in);
    irq <= 1'b1;
    wr(32'h0000_00b0);
    rd();
    chk("clear refused", q[1:0], 2'b11);
    chk("halt refused", q[4], 1'b0);
    @(posedge clk_in);
    irq <= 1'b0;
    wr(cfg | 32'h0000_0010);
    wt(core_en, 1'b0, 4, n);
    @(posedge clk_in);
    irq <= 1'b1;
    wt(core_en, 1'b1, 4, n);
    rd();
    chk("halt cleared", q[4], 1'b0);
    @(posedge clk_in);
    irq <= 1'b0;
  endtask : t_halt

  task automatic t_div();
    wr(cfg | 32'h0600_0000);
    repeat (4) @(negedge clk_in);
    a = 0;
    b = 0;
    repeat (64) begin
      @(negedge clk_in);
      a += int'(sys_en === 1'b1);
      b += int'(mod_en === 1'b1);
    end
    chk("div16 rate", a, 4);
    chk("free module clock", b, 64);
    wr(cfg);
  endtask : t_div

  task automatic t_timer();
    wr(cfg | 32'h0000_2800);
    wt(st_irq, 1'b1, 300, n);
    chk("timer match", n >= 80 && n <= 165, 1'b1);
    @(negedge clk_in);
    chk("timer pulse", st_irq, 1'b0);
  endtask : t_timer

  task automatic t_debounce();
    wr(cfg | 32'h0000_0008);
    @(posedge clk_in);
    btn <= 1'b1;
    wt(rise, 1'b1, 300, n);
    chk("debounce delay", n >= 158 && n <= 245, 1'b1);
    @(posedge clk_in);
    btn <= 1'b0;
  endtask : t_debounce

  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_wake();
    t_settle();
    t_forced();
    t_halt();
    t_div();
    t_timer();
    t_debounce();
    end_of_test();
  end
endmodule : pcs_power_ctrl_tb
